//--- hdl/dtst_map.svh
// Offsets, field positions, codes and counts of the test control word block.
// Assumes plain inclusion by the design file and the testbench.
`ifndef DTST_MAP_SVH
`define DTST_MAP_SVH
`define DT_CMD_W 40
`define DT_CMD_CNT 6'h28
`define DT_ADDR_MSB 39
`define DT_ADDR_LSB 37
`define DT_UPD_BIT 36
`define DT_STORE_W 36
`define DT_TEST_WORD 3'h7
`define DT_CW1_TEST_EN 3
`define DT_F_FORCE_IN 13
`define DT_F_ACC_HI 12
`define DT_F_ACC_LO 11
`define DT_F_QSTB 10
`define DT_F_FORCE 9
`define DT_F_FCLK 8
`define DT_F_FSTB 7
`define DT_F_FI 6
`define DT_F_FQ 5
`define DT_F_SINCOS 4
`define DT_F_SCALE 3
`define DT_F_WAIT 1
`define DT_F_NOOVF 0
`define DT_ACC_RSVD 2'h3
`define DT_ACC_NORMAL 2'h0
`define DT_FORCED_SAMPLE 16'h8000
`define DT_UNITY_SINCOS 20'hfffff
`define DT_RAM_FILL 8'h40
`define DT_IR_W 4
`define DT_IR_CAPTURE 4'h1
`define DT_IR_EXTEST 4'h0
`define DT_IR_SAMPLE 4'h1
`define DT_IR_INTEST 4'h2
`define DT_IR_RUNBIST 4'h3
`define DT_IR_IDCODE 4'h4
`define DT_IR_RDCW_BASE 4'h8
`define DT_IR_RDCW_LAST 4'he
`define DT_IR_BYPASS 4'hf
`define DT_LEN_BYP 6'h01
`define DT_LEN_BSR 6'h04
`define DT_LEN_ID 6'h20
`define DT_LEN_CW 6'h24
`endif

//--- hdl/dtst_pkg.sv
// Types shared by the test control word block.
// Assumes dtst_map.svh is on the include path.
package dtst_pkg;
   typedef logic [35:0] dtst_word_t;
   typedef enum logic [3:0] {
      tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_sh_dr, tap_ex1_dr,
      tap_pa_dr, tap_ex2_dr, tap_up_dr, tap_sel_ir, tap_cap_ir, tap_sh_ir,
      tap_ex1_ir, tap_pa_ir, tap_ex2_ir, tap_up_ir
   } dtst_tap_e;
endpackage

//--- hdl/dtst_ctrl.sv
// Test control word, control word store and scan readback port.
// Assumes the serial control pins are asynchronous to clk_sys_in and the
// scan port runs on its own clock tck_in.
`include "dtst_map.svh"
`timescale 1ns/1ns
`default_nettype none
module dtst_ctrl #(
   parameter logic [31:0] ID_CODE = 32'h00000001 // Arbitrary identity value
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic ser_clk_in,
   input wire logic ser_frame_in,
   input wire logic ser_data_in,
   input wire logic [15:0] sample_in,
   input wire logic [19:0] sin_in,
   input wire logic [19:0] cos_in,
   input wire logic rollover_in,
   input wire logic ram_write_in,
   input wire logic norm_bit_clock_in,
   input wire logic norm_word_strobe_in,
   input wire logic norm_i_in,
   input wire logic norm_q_in,
   output logic [15:0] sample_out,
   output logic [19:0] sin_out,
   output logic [19:0] cos_out,
   output logic [1:0] accum_mode_out,
   output logic scale_bypass_out,
   output logic overflow_prot_out,
   output logic out_enable_out,
   output logic serial_out_bit_clock_out,
   output logic serial_out_word_strobe_out,
   output logic i_out,
   output logic q_out,
   output logic test_active_out,
   input wire logic tck_in,
   input wire logic tap_rst_n_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic tdo_out,
   output logic tdo_oe_n_out
);
   ////////////////////////////////////////////////////////////////////////
   // Serial control port, synchronised to the control clock
   logic [2:0] ser_s1, ser_s2;
   logic ser_clk_d, ser_frame_d;
   logic [39:0] cmd_sh;
   logic [5:0] bit_cnt;
   dtst_pkg::dtst_word_t staged [1:7];
   dtst_pkg::dtst_word_t active [1:7];
   logic cw_toggle, rst_d;

   always_ff @(posedge clk_sys_in) begin
      rst_d <= rst_n_in;
      ser_s1 <= {ser_clk_in, ser_frame_in, ser_data_in};
      ser_s2 <= ser_s1;
      ser_clk_d <= ser_s2[2];
      ser_frame_d <= ser_s2[1];
   end

   wire clk_rise = ser_s2[2] && !ser_clk_d;
   wire frame_fall = ser_frame_d && !ser_s2[1];
   wire cmd_done = frame_fall && (bit_cnt == `DT_CMD_CNT);
   wire [2:0] cmd_addr = cmd_sh[`DT_ADDR_MSB:`DT_ADDR_LSB];
   wire cmd_upd = cmd_sh[`DT_UPD_BIT];
   // Only the payload is kept; routing bits are dropped here
   wire [35:0] cmd_data = cmd_sh[`DT_STORE_W-1:0];
   wire cmd_valid = cmd_done && (cmd_addr != 3'h0);
   // Release re-copies the cleared store to the scan side
   wire rst_rel = rst_n_in && !rst_d;

   // Bit 39 arrives first; short or long frames are discarded
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cmd_sh <= 40'h0;
         bit_cnt <= 6'h0;
      end else if (!ser_s2[1]) begin
         bit_cnt <= 6'h0;
      end else if (clk_rise) begin
         cmd_sh <= {cmd_sh[38:0], ser_s2[0]};
         if (bit_cnt != 6'h3f) begin
            bit_cnt <= bit_cnt + 6'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cw_toggle <= 1'b0;
         for (int k = 1; k <= 7; k++) begin
            staged[k] <= 36'h0;
            active[k] <= 36'h0;
         end
      end else if (cmd_valid || rst_rel) begin
         cw_toggle <= !cw_toggle;
         for (int k = 1; k <= 7; k++) begin
            if (cmd_addr == 3'(k)) begin
               staged[k] <= cmd_data;
               active[k] <= cmd_data;
            end else if (cmd_upd) begin
               active[k] <= staged[k];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Test functions on the datapath
   wire test_en = active[1][`DT_CW1_TEST_EN];
   // Reserved bits travel along but nothing reads them
   wire [35:0] tw = test_en ? active[`DT_TEST_WORD] : 36'h0;
   wire [1:0] acc_field = tw[`DT_F_ACC_HI:`DT_F_ACC_LO];
   logic [7:0] fill_cnt;
   wire ram_full = (fill_cnt == `DT_RAM_FILL);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         fill_cnt <= 8'h0;
      end else if (ram_write_in && !ram_full) begin
         fill_cnt <= fill_cnt + 8'h1;
      end
   end

   wire [15:0] next_sample =
      tw[`DT_F_FORCE_IN] ? `DT_FORCED_SAMPLE : sample_in;
   // Reserved code behaves as normal accumulation
   wire [1:0] next_acc =
      (acc_field == `DT_ACC_RSVD) ? `DT_ACC_NORMAL : acc_field;
   wire next_bypass_sc = tw[`DT_F_SINCOS];
   wire next_force = tw[`DT_F_FORCE];
   wire next_bclk = next_force ? tw[`DT_F_FCLK] : norm_bit_clock_in;
   wire next_wstb = next_force ? tw[`DT_F_FSTB] : norm_word_strobe_in;
   wire next_i = next_force ? tw[`DT_F_FI] : norm_i_in;
   wire next_q_norm = tw[`DT_F_QSTB] ? rollover_in : norm_q_in;
   wire next_q = next_force ? tw[`DT_F_FQ] : next_q_norm;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sample_out <= 16'h0;
         sin_out <= 20'h0;
         cos_out <= 20'h0;
         accum_mode_out <= `DT_ACC_NORMAL;
         scale_bypass_out <= 1'b0;
         overflow_prot_out <= 1'b1;
         out_enable_out <= 1'b0;
         serial_out_bit_clock_out <= 1'b0;
         serial_out_word_strobe_out <= 1'b0;
         i_out <= 1'b0;
         q_out <= 1'b0;
         test_active_out <= 1'b0;
      end else begin
         sample_out <= next_sample;
         sin_out <= next_bypass_sc ? `DT_UNITY_SINCOS : sin_in;
         cos_out <= next_bypass_sc ? `DT_UNITY_SINCOS : cos_in;
         accum_mode_out <= next_acc;
         scale_bypass_out <= tw[`DT_F_SCALE];
         overflow_prot_out <= !tw[`DT_F_NOOVF];
         out_enable_out <= !tw[`DT_F_WAIT] || ram_full;
         serial_out_bit_clock_out <= next_bclk;
         serial_out_word_strobe_out <= next_wstb;
         i_out <= next_i;
         q_out <= next_q;
         test_active_out <= test_en;
      end
   end

   a_force_sample: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) tw[`DT_F_FORCE_IN] |=> sample_out == 16'h8000)
      else $error("forced sample missing");
   // Sampled reset in the antecedent keeps the release edge out
   a_pass_sample: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) rst_n_in && !tw[`DT_F_FORCE_IN] |=>
      sample_out == $past(sample_in)) else $error("sample not passed");
   a_acc_mode: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) acc_field == 2'h2 |=> accum_mode_out == 2'h2)
      else $error("accumulator mode wrong");
   a_q_rollover: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) tw[10] && !tw[9] |=> q_out == $past(rollover_in))
      else $error("rollover strobe wrong");
   a_forced_pins: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) tw[9] |=> {serial_out_bit_clock_out,
      serial_out_word_strobe_out, i_out, q_out} == $past(tw[8:5]))
      else $error("forced pins wrong");
   a_sincos_unity: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) tw[4] |=> sin_out == 20'hfffff &&
      cos_out == 20'hfffff) else $error("sine cosine bypass wrong");
   a_scale_ovf: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) 1'b1 |=> scale_bypass_out == $past(tw[3]) &&
      overflow_prot_out == !$past(tw[0]))
      else $error("scale or overflow flag wrong");
   a_wait_ram: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) tw[1] && !ram_full |=> !out_enable_out)
      else $error("output before RAM filled");
   a_test_gate: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) rst_n_in && !test_en |=> !scale_bypass_out &&
      overflow_prot_out && sample_out == $past(sample_in))
      else $error("test word acting while disabled");
   a_single_update: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) cmd_valid && !cmd_upd && cmd_addr == 3'h7 |=>
      active[7] == $past(cmd_data) && active[1] == $past(active[1]))
      else $error("single update wrong");
   a_all_update: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) cmd_valid && cmd_upd && cmd_addr == 3'h7 |=>
      active[1] == $past(staged[1])) else $error("update all wrong");

   ////////////////////////////////////////////////////////////////////////
   // Scan port on the test clock
   logic [2:0] tog_s;
   dtst_pkg::dtst_word_t shadow [1:7];
   logic [3:0] pin_s1, pin_s2;
   dtst_pkg::dtst_tap_e state, next_state;
   logic [3:0] ir, ir_sh;
   logic [35:0] dr_sh;

   function automatic logic [5:0] dr_len(input logic [3:0] code);
      if (code >= `DT_IR_RDCW_BASE && code <= `DT_IR_RDCW_LAST) begin
         return `DT_LEN_CW;
      end
      case (code)
         `DT_IR_IDCODE: return `DT_LEN_ID;
         `DT_IR_EXTEST, `DT_IR_SAMPLE, `DT_IR_INTEST: return `DT_LEN_BSR;
         default: return `DT_LEN_BYP;
      endcase
   endfunction

   function automatic logic [35:0] dr_shift(input logic [35:0] sh,
      input logic din, input logic [5:0] len);
      logic [35:0] res;
      res = 36'h0;
      for (int i = 0; i < 36; i++) begin
         if (i == 32'(len) - 1) begin
            res[i] = din;
         end else if (i < 35) begin
            res[i] = sh[i + 1];
         end
      end
      return res;
   endfunction

   // Words are copied only after the toggle settles; the store holds
   // still between commands, so the copy is stable
   wire cw_changed = tog_s[2] != tog_s[1];
   wire is_rdcw = ir >= `DT_IR_RDCW_BASE && ir <= `DT_IR_RDCW_LAST;
   wire [2:0] rd_sel = 3'(ir - `DT_IR_RDCW_BASE) + 3'h1;
   wire [35:0] cap_val =
      is_rdcw ? shadow[rd_sel] :
      (ir == `DT_IR_IDCODE) ? {4'h0, ID_CODE} :
      (dr_len(ir) == `DT_LEN_BSR) ? {32'h0, pin_s2} : 36'h0;

   always_comb begin
      unique case (state)
         dtst_pkg::tap_reset: next_state = tms_in ? dtst_pkg::tap_reset
            : dtst_pkg::tap_idle;
         dtst_pkg::tap_idle, dtst_pkg::tap_up_dr, dtst_pkg::tap_up_ir:
            next_state = tms_in ? dtst_pkg::tap_sel_dr : dtst_pkg::tap_idle;
         dtst_pkg::tap_sel_dr: next_state = tms_in ? dtst_pkg::tap_sel_ir
            : dtst_pkg::tap_cap_dr;
         dtst_pkg::tap_cap_dr, dtst_pkg::tap_sh_dr, dtst_pkg::tap_ex2_dr:
            next_state = tms_in ? dtst_pkg::tap_ex1_dr : dtst_pkg::tap_sh_dr;
         dtst_pkg::tap_ex1_dr: next_state = tms_in ? dtst_pkg::tap_up_dr
            : dtst_pkg::tap_pa_dr;
         dtst_pkg::tap_pa_dr: next_state = tms_in ? dtst_pkg::tap_ex2_dr
            : dtst_pkg::tap_pa_dr;
         dtst_pkg::tap_sel_ir: next_state = tms_in ? dtst_pkg::tap_reset
            : dtst_pkg::tap_cap_ir;
         dtst_pkg::tap_cap_ir, dtst_pkg::tap_sh_ir, dtst_pkg::tap_ex2_ir:
            next_state = tms_in ? dtst_pkg::tap_ex1_ir : dtst_pkg::tap_sh_ir;
         dtst_pkg::tap_ex1_ir: next_state = tms_in ? dtst_pkg::tap_up_ir
            : dtst_pkg::tap_pa_ir;
         dtst_pkg::tap_pa_ir: next_state = tms_in ? dtst_pkg::tap_ex2_ir
            : dtst_pkg::tap_pa_ir;
      endcase
   end

   always_ff @(posedge tck_in) begin
      tog_s <= {tog_s[1:0], cw_toggle};
      pin_s1 <= {serial_out_bit_clock_out, serial_out_word_strobe_out,
         i_out, q_out};
      pin_s2 <= pin_s1;
      if (cw_changed) begin
         for (int k = 1; k <= 7; k++) begin
            shadow[k] <= active[k];
         end
      end
   end

   always_ff @(posedge tck_in) begin
      if (!tap_rst_n_in) begin
         state <= dtst_pkg::tap_reset;
         ir <= `DT_IR_IDCODE;
         ir_sh <= 4'h0;
         dr_sh <= 36'h0;
      end else begin
         state <= next_state;
         if (state == dtst_pkg::tap_reset) begin
            ir <= `DT_IR_IDCODE;
         end else if (state == dtst_pkg::tap_up_ir) begin
            ir <= ir_sh;
         end
         if (state == dtst_pkg::tap_cap_ir) begin
            ir_sh <= `DT_IR_CAPTURE;
         end else if (state == dtst_pkg::tap_sh_ir) begin
            ir_sh <= {tdi_in, ir_sh[3:1]};
         end
         if (state == dtst_pkg::tap_cap_dr) begin
            dr_sh <= cap_val;
         end else if (state == dtst_pkg::tap_sh_dr) begin
            dr_sh <= dr_shift(dr_sh, tdi_in, dr_len(ir));
         end
      end
   end

   // Scan output changes on the falling edge, as the standard requires
   always_ff @(negedge tck_in) begin
      if (!tap_rst_n_in) begin
         tdo_out <= 1'b0;
         tdo_oe_n_out <= 1'b1;
      end else begin
         tdo_out <= (state == dtst_pkg::tap_sh_ir) ? ir_sh[0] : dr_sh[0];
         tdo_oe_n_out <= !(state == dtst_pkg::tap_sh_ir ||
            state == dtst_pkg::tap_sh_dr);
      end
   end

   a_tap_reset: assert property (@(posedge tck_in)
      disable iff (!tap_rst_n_in) tms_in [*5] |=>
      state == dtst_pkg::tap_reset) else $error("five TMS ones did not reset");
   a_rdcw_capture: assert property (@(posedge tck_in)
      disable iff (!tap_rst_n_in) state == dtst_pkg::tap_cap_dr && ir == 4'he
      |=> dr_sh == $past(shadow[7]))
      else $error("control word readback wrong");
   a_scan_drive: assert property (@(negedge tck_in)
      disable iff (!tap_rst_n_in) state == dtst_pkg::tap_sh_dr ||
      state == dtst_pkg::tap_sh_ir |=> !tdo_oe_n_out)
      else $error("scan output idle while shifting");
endmodule
`default_nettype wire

//--- verif/dtst_host.sv
// Host processor and scan tester model facing the test control word block.
// Assumes clk_sys_in paces the serial pins; the scan clock runs on its own.
`timescale 1ns/1ns
`default_nettype none
module dtst_host (
   input wire logic clk_sys_in,
   input wire logic tdo_in,
   output logic ser_clk_out,
   output logic ser_frame_out,
   output logic ser_data_out,
   output logic tck_out,
   output logic tap_rst_n_out,
   output logic tms_out,
   output logic tdi_out
);
   initial begin
      ser_clk_out = 1'b0;
      ser_frame_out = 1'b0;
      ser_data_out = 1'b0;
      tck_out = 1'b0;
      tap_rst_n_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   always #3 tck_out = ~tck_out;
   //////////////////////////////////////////////////////////////////////
   task automatic wait_sys(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   // Top nb bits, first bit 39; bit clock idles low outside frames
   task automatic send(input logic [39:0] cmd, input int nb);
      logic [39:0] c;
      c = cmd;
      if (c[39:37] == 3'h7) begin
         c[35:14] = 22'h0;
         c[2] = 1'b0;
      end
      @(posedge clk_sys_in);
      ser_frame_out <= 1'b1;
      for (int i = 39; i > 39 - nb; i--) begin
         ser_data_out <= c[i];
         wait_sys(4);
         ser_clk_out <= 1'b1;
         wait_sys(4);
         ser_clk_out <= 1'b0;
      end
      wait_sys(4);
      ser_frame_out <= 1'b0;
      ser_data_out <= ~c[40 - nb];
      wait_sys(12);
   endtask
   // Data read here was launched on the previous falling edge
   task automatic step(input logic ms, input logic di, output logic dv);
      @(posedge tck_out);
      dv = tdo_in;
      tms_out <= ms;
      tdi_out <= di;
   endtask
   task automatic tap_reset();
      logic d;
      @(posedge tck_out);
      tap_rst_n_out <= 1'b0;
      repeat (3) step(1'b1, 1'b0, d);
      tap_rst_n_out <= 1'b1;
      step(1'b0, 1'b0, d);
      step(1'b0, 1'b0, d);
      // Five ones from idle must walk the controller back to reset
      repeat (5) step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
      step(1'b0, 1'b0, d);
   endtask
   task automatic scan(input logic ir, input logic [35:0] din, input int n,
         output logic [35:0] dout);
      logic d;
      dout = '0;
      step(1'b1, 1'b0, d);
      if (ir) step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
      step(1'b0, 1'b0, d);
      for (int j = 0; j < n; j++) begin
         step(j == n - 1, din[j], d);
         if (j > 0) dout[j - 1] = d;
      end
      step(1'b1, ~din[n - 1], d);
      dout[n - 1] = d;
      step(1'b0, din[n - 1], d);
      step(1'b0, ~din[n - 1], d);
   endtask
endmodule
`default_nettype wire

//--- verif/dtst_ctrl_tb.sv
// Self-checking bench for the test control word block.
// Assumes dtst_host drives the serial control and scan pins.
`timescale 1ns/1ns
`default_nettype none
`include "dtst_map.svh"
module dtst_ctrl_tb;
   localparam logic [31:0] TB_ID = 32'h0000a5c3; // Arbitrary value
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] smp = 16'h1234;
   logic [19:0] sin_v = 20'h12345;
   logic [19:0] cos_v = 20'h6789a;
   logic roll = 1'b0;
   logic ram_wr = 1'b0;
   logic [3:0] norm = 4'h0;
   logic ser_clk, ser_frame, ser_data, tck, tap_rst_n, tms, tdi;
   logic [15:0] smp_o;
   logic [19:0] sin_o, cos_o;
   logic [1:0] acc_o;
   logic scale_o, ovf_o, oen_o, bclk_o, stb_o, i_o, q_o, act_o;
   logic tdo, tdo_oe_n;
   int n_mismatch = 0;
   int num_checks = 0;
   always #5 clk_sys = ~clk_sys;
   dtst_host h (.clk_sys_in(clk_sys), .tdo_in(tdo), .ser_clk_out(ser_clk),
      .ser_frame_out(ser_frame), .ser_data_out(ser_data), .tck_out(tck),
      .tap_rst_n_out(tap_rst_n), .tms_out(tms), .tdi_out(tdi));
   dtst_ctrl #(.ID_CODE(TB_ID)) DUT (
      .clk_sys_in(clk_sys), .rst_n_in(rst_n), .ser_clk_in(ser_clk),
      .ser_frame_in(ser_frame), .ser_data_in(ser_data), .sample_in(smp),
      .sin_in(sin_v), .cos_in(cos_v), .rollover_in(roll),
      .ram_write_in(ram_wr), .norm_bit_clock_in(norm[3]),
      .norm_word_strobe_in(norm[2]), .norm_i_in(norm[1]),
      .norm_q_in(norm[0]), .sample_out(smp_o), .sin_out(sin_o),
      .cos_out(cos_o), .accum_mode_out(acc_o), .scale_bypass_out(scale_o),
      .overflow_prot_out(ovf_o), .out_enable_out(oen_o),
      .serial_out_bit_clock_out(bclk_o), .serial_out_word_strobe_out(stb_o),
      .i_out(i_o), .q_out(q_o), .test_active_out(act_o), .tck_in(tck),
      .tap_rst_n_in(tap_rst_n), .tms_in(tms), .tdi_in(tdi),
      .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n));
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [35:0] exp,
         input logic [35:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test();
      if (n_mismatch == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic u,
         input logic [35:0] p);
      h.send({a, u, p}, 40);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Whole run is near 6k system cycles; this bound only cuts a hang
   initial begin
      #150000;
      n_mismatch++;
      end_of_test();
   end
   initial begin : main
      logic [35:0] d;
      logic [35:0] expw [1:7];
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      h.tap_reset();
      settle(2);
      chk("overflow_prot", 36'h1, 36'(ovf_o));
      chk("out_enable", 36'h1, 36'(oen_o));
      h.scan(1'b0, 36'h0, `DT_LEN_ID, d);
      chk("idcode", 36'(TB_ID), d);
      h.scan(1'b1, 36'(`DT_IR_BYPASS), `DT_IR_W, d);
      chk("ir_capture", 36'(`DT_IR_CAPTURE), d);
      h.scan(1'b0, 36'hb, 4, d);
      chk("bypass", 36'h6, d);
      chk("tdo_oe_n", 36'h1, 36'(tdo_oe_n));
      // Word 7 loaded while test enable is off must not act
      wr(3'h7, 1'b0, 36'h3019);
      @(posedge clk_sys);
      smp <= 16'h7e01;
      settle(2);
      chk("sample_off", 36'h7e01, 36'(smp_o));
      wr(3'h1, 1'b1, 36'h8);
      settle(2);
      chk("test_active", 36'h1, 36'(act_o));
      chk("sample", 36'(`DT_FORCED_SAMPLE), 36'(smp_o));
      chk("sin", 36'hfffff, 36'(sin_o));
      chk("cos", 36'hfffff, 36'(cos_o));
      chk("scale_bypass", 36'h1, 36'(scale_o));
      chk("overflow_prot", 36'h0, 36'(ovf_o));
      h.send({3'h7, 1'b0, 36'h0}, 39);
      h.send(40'h0, 40);
      settle(2);
      chk("sample_kept", 36'h8000, 36'(smp_o));
      for (int k = 0; k < 4; k++) begin
         wr(3'h7, k[0], 36'(k) << 11);
         settle(2);
         chk("accum", (k == 3) ? 36'h0 : 36'(k), 36'(acc_o));
      end
      @(posedge clk_sys);
      norm <= 4'h5;
      wr(3'h7, 1'b0, 36'h340);
      settle(2);
      chk("forced_pins", 36'ha, 36'({bclk_o, stb_o, i_o, q_o}));
      wr(3'h7, 1'b1, 36'h400);
      @(posedge clk_sys);
      roll <= 1'b1;
      settle(1);
      chk("q_strobe", 36'h1, 36'(q_o));
      chk("normal_pins", 36'h2, 36'({bclk_o, stb_o, i_o}));
      @(posedge clk_sys);
      roll <= 1'b0;
      settle(1);
      chk("q_strobe", 36'h0, 36'(q_o));
      expw[1] = 36'h8;
      expw[7] = 36'h400;
      for (int k = 2; k < 7; k++) begin
         expw[k] = 36'h9a5c30000 | 36'(k);
         wr(3'(k), k[0], expw[k]);
      end
      for (int k = 1; k < 8; k++) begin
         h.scan(1'b1, 36'(`DT_IR_RDCW_BASE + k - 1), `DT_IR_W, d);
         h.scan(1'b0, 36'h0, `DT_LEN_CW, d);
         chk("readback", expw[k], d);
      end
      @(posedge clk_sys);
      rst_n <= 1'b0;
      settle(2);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      wr(3'h1, 1'b0, 36'h8);
      wr(3'h7, 1'b0, 36'h2);
      settle(2);
      chk("out_enable", 36'h0, 36'(oen_o));
      for (int i = 0; i < `DT_RAM_FILL; i++) begin
         if (i == `DT_RAM_FILL - 1) begin
            settle(2);
            chk("out_enable", 36'h0, 36'(oen_o));
         end
         @(posedge clk_sys);
         ram_wr <= 1'b1;
         @(posedge clk_sys);
         ram_wr <= 1'b0;
      end
      settle(3);
      chk("out_enable", 36'h1, 36'(oen_o));
      end_of_test();
   end
endmodule
`default_nettype wire
